//--- image_decode_pkg.sv
package image_decode_pkg;

   // Register offsets.
   localparam logic [11:0] OFF_BASE    = 12'h12C;
   localparam logic [11:0] OFF_BOUND   = 12'h130;
   localparam logic [11:0] OFF_OFFSET  = 12'h134;
   localparam logic [11:0] OFF_CONTROL = 12'h13C;
   localparam logic [11:0] OFF_STATUS  = 12'h1F0;

   // Field positions.
   localparam int HI_MSB      = 31;
   localparam int HI_LSB      = 16;
   localparam int EN_BIT      = 31;
   localparam int POST_BIT    = 30;
   localparam int WID_MSB     = 23;
   localparam int WID_LSB     = 22;
   localparam int SPC_MSB     = 18;
   localparam int SPC_LSB     = 16;
   localparam int PROG_BIT    = 14;
   localparam int SUP_BIT     = 12;
   localparam int BLK_BIT     = 8;
   localparam int IOSP_BIT    = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_POST_BIT = 1;
   localparam int ST_MISS_BIT = 2;

   // Encodings and reset values.
   localparam logic [1:0]  W8        = 2'h0;
   localparam logic [1:0]  W16       = 2'h1;
   localparam logic [1:0]  W32       = 2'h2;
   localparam logic [1:0]  W64       = 2'h3;
   localparam logic [2:0]  SP_A16    = 3'h0;
   localparam logic [2:0]  SP_A24    = 3'h1;
   localparam logic [2:0]  SP_A32    = 3'h2;
   localparam logic [1:0]  WID_RST   = W32;
   localparam logic [2:0]  SPC_RST   = SP_A16;
   localparam logic [15:0] HALF_ZERO = 16'h0000;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // Transfer sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b001,
      ST_COUPLED = 3'b010,
      ST_POSTED  = 3'b100
   } txn_state_t;

endpackage

//--- image_cfg_if.sv
`timescale 1ns/100ps
// Window settings toward the decoder and its answer back.
interface image_cfg_if;
   logic        enable;
   logic        io_space;
   logic [15:0] base;
   logic [15:0] bound;
   logic [15:0] offset;
   logic [2:0]  space;
   logic [1:0]  width;
   logic        block_sel;
   logic [31:0] pci_addr;
   logic        pci_io;
   logic        hit;
   logic [31:0] vme_addr;
   logic        blt_allow;
   logic        mblt_allow;

   modport regs (output enable, io_space, base, bound, offset, space, width,
                 block_sel, pci_addr, pci_io,
                 input  hit, vme_addr, blt_allow, mblt_allow);
   modport decode (input  enable, io_space, base, bound, offset, space, width,
                   block_sel, pci_addr, pci_io,
                   output hit, vme_addr, blt_allow, mblt_allow);
endinterface // image_cfg_if

//--- image_window_decode.sv
`timescale 1ns/100ps
// Pure combinational window match, translation and cycle-type decision.
module image_window_decode
   import image_decode_pkg::*;
(
   image_cfg_if.decode cfg
);
   logic [15:0] hi;
   logic        above_base;
   logic        below_bound;
   logic        a24_a32;

   // ------------------------------------------------------------
   // Window match
   // ------------------------------------------------------------
   // Compare the upper half of the PCI address against the limits.
   always_comb begin
      hi          = cfg.pci_addr[HI_MSB:HI_LSB];
      above_base  = (hi >= cfg.base);
      below_bound = (cfg.bound == HALF_ZERO) || (hi < cfg.bound);
      cfg.hit     = cfg.enable
                    && (cfg.pci_io == cfg.io_space)
                    && above_base && below_bound;
   end

   // ------------------------------------------------------------
   // Translation and block-transfer permission
   // ------------------------------------------------------------
   // Upper half is a wrapping sum; the low half is passed through.
   always_comb begin
      cfg.vme_addr = {16'(hi + cfg.offset),
                      cfg.pci_addr[HI_LSB-1:0]};
      a24_a32        = (cfg.space == SP_A24) || (cfg.space == SP_A32);
      cfg.blt_allow  = cfg.block_sel && a24_a32 && (cfg.width != W64);
      cfg.mblt_allow = a24_a32 && (cfg.width == W64);
   end
endmodule // image_window_decode

//--- pci_to_vme_image_decode.sv
`timescale 1ns/100ps
// One PCI-to-VME target window: APB registers, decode and a one-deep post.
module pci_to_vme_image_decode
   import image_decode_pkg::*;
#(
   parameter int DATA_W = 32
)(
   input  wire logic              REF_CLK,
   input  wire logic              RST_N,
   // APB slave.
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // PCI target request side.
   input  wire logic              PCI_REQ,
   input  wire logic [31:0]       PCI_ADDR,
   input  wire logic              PCI_IO,
   input  wire logic              PCI_WRITE,
   input  wire logic [DATA_W-1:0] PCI_WDATA,
   output logic                   PCI_DONE,
   output logic                   PCI_MISS,
   output logic                   PCI_BUSY,
   output logic      [DATA_W-1:0] PCI_RDATA,
   // VME cycle engine side.
   output logic                   VME_REQ,
   output logic                   VME_WRITE,
   output logic      [31:0]       VME_ADDR,
   output logic      [DATA_W-1:0] VME_WDATA,
   output logic      [2:0]        VME_SPACE,
   output logic      [1:0]        VME_WIDTH,
   output logic                   VME_PROGRAM,
   output logic                   VME_SUPERVISOR,
   output logic                   VME_BLT_ALLOW,
   output logic                   VME_MBLT_ALLOW,
   input  wire logic              VME_ACK,
   input  wire logic [DATA_W-1:0] VME_RDATA
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   // The data path is one APB word at most.
   if (DATA_W < 8 || DATA_W > 32) begin : g_bad_width
      $error("DATA_W must lie between 8 and 32.");
   end

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
      logic [15:0]       base;
      logic [15:0]       bound;
      logic [15:0]       offset;
      logic              en;
      logic              post_ok;
      logic [1:0]        wid;
      logic [2:0]        spc;
      logic              prog;
      logic              sup;
      logic              blk;
      logic              iosp;
      txn_state_t        st;
      logic              last_miss;
      logic [15:0]       claims;
      logic              pci_done;
      logic              pci_miss;
      logic              pci_busy;
      logic [DATA_W-1:0] pci_rdata;
      logic              vme_req;
      logic              vme_write;
      logic [31:0]       vme_addr;
      logic [DATA_W-1:0] vme_wdata;
      logic [2:0]        vme_space;
      logic [1:0]        vme_width;
      logic              vme_program;
      logic              vme_super;
      logic              vme_blt;
      logic              vme_mblt;
   } state_t;

   // Reset image; undefined bits of the control word come up cleared.
   localparam state_t RST_STATE = '{
      pready:      1'b0,
      pslverr:     1'b0,
      prdata:      WORD_ZERO,
      base:        HALF_ZERO,
      bound:       HALF_ZERO,
      offset:      HALF_ZERO,
      en:          1'b0,
      post_ok:     1'b0,
      wid:         WID_RST,
      spc:         SPC_RST,
      prog:        1'b0,
      sup:         1'b0,
      blk:         1'b0,
      iosp:        1'b0,
      st:          ST_IDLE,
      last_miss:   1'b0,
      claims:      HALF_ZERO,
      pci_done:    1'b0,
      pci_miss:    1'b0,
      pci_busy:    1'b0,
      pci_rdata:   '0,
      vme_req:     1'b0,
      vme_write:   1'b0,
      vme_addr:    WORD_ZERO,
      vme_wdata:   '0,
      vme_space:   SP_A16,
      vme_width:   WID_RST,
      vme_program: 1'b0,
      vme_super:   1'b0,
      vme_blt:     1'b0,
      vme_mblt:    1'b0
   };

   state_t      r;
   state_t      next_r;
   logic        access;
   logic        do_write;
   logic        posted;
   logic [31:0] ctl_word;
   logic [31:0] stat_word;

   image_cfg_if cfg ();

   // ------------------------------------------------------------
   // Decoder
   // ------------------------------------------------------------
   // Present the live settings and the incoming address.
   assign cfg.enable    = r.en;
   assign cfg.io_space  = r.iosp;
   assign cfg.base      = r.base;
   assign cfg.bound     = r.bound;
   assign cfg.offset    = r.offset;
   assign cfg.space     = r.spc;
   assign cfg.width     = r.wid;
   assign cfg.block_sel = r.blk;
   assign cfg.pci_addr  = PCI_ADDR;
   assign cfg.pci_io    = PCI_IO;

   image_window_decode u_decode (
      .cfg (cfg.decode)
   );

   // ------------------------------------------------------------
   // Read views
   // ------------------------------------------------------------
   // Assemble the control and status words; reserved bits read zero.
   always_comb begin
      ctl_word                   = WORD_ZERO;
      ctl_word[EN_BIT]           = r.en;
      ctl_word[POST_BIT]         = r.post_ok;
      ctl_word[WID_MSB:WID_LSB]  = r.wid;
      ctl_word[SPC_MSB:SPC_LSB]  = r.spc;
      ctl_word[PROG_BIT]         = r.prog;
      ctl_word[SUP_BIT]          = r.sup;
      ctl_word[BLK_BIT]          = r.blk;
      ctl_word[IOSP_BIT]         = r.iosp;
      stat_word                  = WORD_ZERO;
      stat_word[ST_BUSY_BIT]     = r.pci_busy;
      stat_word[ST_POST_BIT]     = (r.st == ST_POSTED);
      stat_word[ST_MISS_BIT]     = r.last_miss;
      stat_word[HI_MSB:HI_LSB]   = r.claims;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r          = r;
      next_r.pci_done = 1'b0;
      next_r.pci_miss = 1'b0;

      // APB answers one cycle into the access phase.
      access   = PSEL && PENABLE;
      do_write = access && r.pready && PWRITE && !r.pslverr;
      next_r.pready = access && !r.pready;
      if (access && !r.pready) begin
         next_r.pslverr = 1'b0;
         next_r.prdata  = WORD_ZERO;
         case (PADDR)
            OFF_BASE:    next_r.prdata = {r.base, HALF_ZERO};
            OFF_BOUND:   next_r.prdata = {r.bound, HALF_ZERO};
            OFF_OFFSET:  next_r.prdata = {r.offset, HALF_ZERO};
            OFF_CONTROL: next_r.prdata = ctl_word;
            OFF_STATUS:  next_r.prdata = stat_word;
            default:     next_r.pslverr = 1'b1;
         endcase
      end else if (!access) begin
         next_r.pslverr = 1'b0;
      end

      // Writes land at the edge where the master sees PREADY high.
      if (do_write) begin
         case (PADDR)
            OFF_BASE: begin
               next_r.base = PWDATA[HI_MSB:HI_LSB];
            end
            OFF_BOUND: begin
               next_r.bound = PWDATA[HI_MSB:HI_LSB];
            end
            OFF_OFFSET: begin
               next_r.offset = PWDATA[HI_MSB:HI_LSB];
            end
            OFF_CONTROL: begin
               next_r.en   = PWDATA[EN_BIT];
               next_r.post_ok = PWDATA[POST_BIT];
               next_r.wid     = PWDATA[WID_MSB:WID_LSB];
               next_r.spc     = PWDATA[SPC_MSB:SPC_LSB];
               next_r.prog    = PWDATA[PROG_BIT];
               next_r.sup     = PWDATA[SUP_BIT];
               next_r.blk     = PWDATA[BLK_BIT];
               next_r.iosp    = PWDATA[IOSP_BIT];
            end
            default: begin
               next_r.last_miss = r.last_miss;
            end
         endcase
      end

      // Posting needs a memory-space write with posting allowed.
      posted = r.post_ok && !r.iosp && PCI_WRITE;

      // Transfer sequencer; requests while busy are not taken.
      case (r.st)
         ST_IDLE: begin
            if (PCI_REQ) begin
               if (cfg.hit) begin
                  next_r.last_miss   = 1'b0;
                  next_r.claims      = r.claims + 16'h0001;
                  next_r.pci_busy    = 1'b1;
                  next_r.vme_req     = 1'b1;
                  next_r.vme_write   = PCI_WRITE;
                  next_r.vme_addr    = cfg.vme_addr;
                  next_r.vme_wdata   = PCI_WDATA;
                  next_r.vme_space   = r.spc;
                  next_r.vme_width   = r.wid;
                  next_r.vme_program = r.prog;
                  next_r.vme_super   = r.sup;
                  next_r.vme_blt     = cfg.blt_allow;
                  next_r.vme_mblt    = cfg.mblt_allow;
                  if (posted) begin
                     // The PCI side is released before the VME cycle ends.
                     next_r.pci_done  = 1'b1;
                     next_r.pci_rdata = '0;
                     next_r.st        = ST_POSTED;
                  end else begin
                     next_r.st = ST_COUPLED;
                  end
               end else begin
                  next_r.pci_miss  = 1'b1;
                  next_r.last_miss = 1'b1;
               end
            end
         end

         ST_COUPLED: begin
            // The PCI cycle ends only when the VME cycle has ended.
            if (VME_ACK) begin
               next_r.vme_req   = 1'b0;
               next_r.pci_busy  = 1'b0;
               next_r.pci_done  = 1'b1;
               next_r.pci_rdata = r.vme_write ? '0 : VME_RDATA;
               next_r.st        = ST_IDLE;
            end
         end

         ST_POSTED: begin
            // The held write drains; nothing returns to PCI.
            if (VME_ACK) begin
               next_r.vme_req  = 1'b0;
               next_r.pci_busy = 1'b0;
               next_r.st       = ST_IDLE;
            end
         end

         default: begin
            next_r.vme_req  = 1'b0;
            next_r.pci_busy = 1'b0;
            next_r.st       = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Register
   // ------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_N) begin
      if (!RST_N) begin
         r <= RST_STATE;
      end else begin
         r <= next_r;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Every output is a field of the registered state.
   assign PRDATA         = r.prdata;
   assign PREADY         = r.pready;
   assign PSLVERR        = r.pslverr;
   assign PCI_DONE       = r.pci_done;
   assign PCI_MISS       = r.pci_miss;
   assign PCI_BUSY       = r.pci_busy;
   assign PCI_RDATA      = r.pci_rdata;
   assign VME_REQ        = r.vme_req;
   assign VME_WRITE      = r.vme_write;
   assign VME_ADDR       = r.vme_addr;
   assign VME_WDATA      = r.vme_wdata;
   assign VME_SPACE      = r.vme_space;
   assign VME_WIDTH      = r.vme_width;
   assign VME_PROGRAM    = r.vme_program;
   assign VME_SUPERVISOR = r.vme_super;
   assign VME_BLT_ALLOW  = r.vme_blt;
   assign VME_MBLT_ALLOW = r.vme_mblt;

endmodule // pci_to_vme_image_decode

//--- image_decode_checker_properties.sv
`timescale 1ns/100ps
// ----------------------------------------
// Port checker for the image window.
// ----------------------------------------
module image_decode_checker
   import image_decode_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        PCI_REQ,
   input wire logic [31:0] PCI_ADDR,
   input wire logic        PCI_IO,
   input wire logic        PCI_WRITE,
   input wire logic        PCI_DONE,
   input wire logic        PCI_MISS,
   input wire logic        PCI_BUSY,
   input wire logic        VME_REQ,
   input wire logic [31:0] VME_ADDR,
   input wire logic [2:0]  VME_SPACE,
   input wire logic [1:0]  VME_WIDTH,
   input wire logic        VME_BLT_ALLOW,
   input wire logic        VME_MBLT_ALLOW,
   input wire logic        VME_ACK
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);
   logic        blk_sp;
   logic [15:0] pci_low;
   // Block-capable spaces and the untranslated low address half.
   assign blk_sp = (VME_SPACE == SP_A24) || (VME_SPACE == SP_A32);
   assign pci_low = PCI_ADDR[15:0];

   blt_gate_a: assert property (VME_REQ && VME_BLT_ALLOW |-> blk_sp && VME_WIDTH != W64)
      else $error("Block transfer allowed outside its space or width.");
   mblt_gate_a: assert property (VME_REQ && blk_sp && VME_WIDTH == W64 |-> VME_MBLT_ALLOW)
      else $error("Wide block transfer not allowed at 64 bits.");
   mblt_width_a: assert property (VME_REQ && VME_MBLT_ALLOW |-> blk_sp && VME_WIDTH == W64)
      else $error("Wide block transfer allowed below 64 bits.");
   io_coupled_a: assert property (PCI_REQ && !PCI_BUSY && PCI_IO |=> !PCI_DONE)
      else $error("I/O transfer completed before the VME cycle.");
   low_addr_a: assert property ($rose(VME_REQ) |-> VME_ADDR[15:0] == $past(pci_low))
      else $error("Low address half changed on translation.");
   miss_quiet_a: assert property (PCI_MISS |-> !VME_REQ && !PCI_BUSY && !PCI_DONE)
      else $error("Missed request started a VME cycle.");
   hold_req_a: assert property (VME_REQ && !VME_ACK |=> VME_REQ && $stable(VME_ADDR))
      else $error("VME request dropped or moved before acknowledge.");
   ack_end_a: assert property (VME_REQ && VME_ACK |=> !VME_REQ && !PCI_BUSY)
      else $error("VME cycle did not end after acknowledge.");
   posted_early_a: assert property ($rose(VME_REQ) && PCI_DONE |-> $past(PCI_WRITE) && !$past(PCI_IO))
      else $error("Early completion given to a non-posted transfer.");
endmodule // image_decode_checker

//--- vme_engine_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Stand-in for the VME cycle engine.
// ----------------------------------------
module vme_engine_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        req,
   input  wire logic [31:0] addr,
   input  wire logic [3:0]  lat,
   output logic             ack,
   output logic [31:0]      rdata
);
   logic [3:0] cnt;
   // Acknowledges one cycle after lat waits; read data is the address with halves
   // swapped, and the data lines toggle every cycle so stale data never looks valid.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
         cnt <= 4'h0;
         rdata <= 32'h5A5A_A5A5;
      end else begin
         ack <= req && !ack && (cnt == lat);
         cnt <= (req && !ack) ? cnt + 4'h1 : 4'h0;
         rdata <= (req && !ack && cnt == lat) ? {addr[15:0], addr[31:16]} : ~rdata;
      end
   end
endmodule // vme_engine_model

//--- pci_to_vme_image_decode_tb.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench for the image window.
// ----------------------------------------
module pci_to_vme_image_decode_tb;
   import image_decode_pkg::*;
   logic REF_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR;
   logic PCI_REQ = 0, PCI_IO = 0, PCI_WRITE = 0, PCI_DONE, PCI_MISS, PCI_BUSY;
   logic VME_REQ, VME_WRITE, VME_PROGRAM, VME_SUPERVISOR, VME_BLT_ALLOW, VME_MBLT_ALLOW;
   logic [11:0] PADDR = 0;
   logic [31:0] PWDATA = 0, PRDATA, PCI_ADDR = 0, PCI_WDATA = 0, PCI_RDATA;
   logic [31:0] VME_ADDR, VME_WDATA, VME_RDATA, rd, v_addr, v_wd, p_rd, nd;
   logic [2:0]  VME_SPACE, v_sp;
   logic [1:0]  VME_WIDTH, v_w;
   logic [4:0]  v_fl;
   logic [3:0]  lat = 0;
   logic        VME_ACK, err, hit, early, eb, em;
   int          miscompares = 0, checked = 0;
   logic [31:0] wa [4] = '{32'h0FFF_FFFC, 32'h1000_0004, 32'h1FFF_FFF0, 32'h2000_0000};

   // Clock at 40 MHz.
   always #12.5 REF_CLK = ~REF_CLK;

   pci_to_vme_image_decode DUT (.REF_CLK(REF_CLK), .RST_N(RST_N), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
      .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PCI_REQ(PCI_REQ),
      .PCI_ADDR(PCI_ADDR), .PCI_IO(PCI_IO), .PCI_WRITE(PCI_WRITE), .PCI_WDATA(PCI_WDATA),
      .PCI_DONE(PCI_DONE), .PCI_MISS(PCI_MISS), .PCI_BUSY(PCI_BUSY), .PCI_RDATA(PCI_RDATA),
      .VME_REQ(VME_REQ), .VME_WRITE(VME_WRITE), .VME_ADDR(VME_ADDR), .VME_WDATA(VME_WDATA),
      .VME_SPACE(VME_SPACE), .VME_WIDTH(VME_WIDTH), .VME_PROGRAM(VME_PROGRAM),
      .VME_SUPERVISOR(VME_SUPERVISOR), .VME_BLT_ALLOW(VME_BLT_ALLOW),
      .VME_MBLT_ALLOW(VME_MBLT_ALLOW), .VME_ACK(VME_ACK), .VME_RDATA(VME_RDATA));
   vme_engine_model engine (.clk(REF_CLK), .rst_n(RST_N), .req(VME_REQ), .addr(VME_ADDR),
      .lat(lat), .ack(VME_ACK), .rdata(VME_RDATA));

   // Verdict and end of run.
   task conclude;
      $display("Comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // APB transfer: setup, access, hold until ready is seen at an edge.
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge REF_CLK);
      PSEL <= 1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge REF_CLK);
      PENABLE <= 1;
      for (n = 0; n < 20; n++) begin
         @(posedge REF_CLK);
         #1;
         if (PREADY === 1'b1) break;
      end
      if (n == 20) begin
         miscompares++;
         conclude();
      end
      rd = PRDATA;
      err = PSLVERR;
      @(posedge REF_CLK);
      PSEL <= 0;
      PENABLE <= 0;
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] exp, input logic e);
      apb(0, a, 0);
      chk(err, e);
      if (!e) chk(rd, exp);
   endtask

   // One PCI request; records the VME cycle it caused and how it completed.
   task pci_op(input logic [31:0] a, input logic io, input logic wr);
      int n;
      @(posedge REF_CLK);
      PCI_REQ <= 1;
      PCI_ADDR <= a;
      PCI_IO <= io;
      PCI_WRITE <= wr;
      PCI_WDATA <= ~a;
      @(posedge REF_CLK);
      PCI_REQ <= 0;
      #1;
      hit = (PCI_MISS !== 1'b1);
      early = PCI_DONE;
      nd = {31'h0, PCI_DONE};
      p_rd = PCI_RDATA;
      v_addr = VME_ADDR;
      v_wd = VME_WDATA;
      v_sp = VME_SPACE;
      v_w = VME_WIDTH;
      v_fl = {VME_WRITE, VME_PROGRAM, VME_SUPERVISOR, VME_BLT_ALLOW, VME_MBLT_ALLOW};
      for (n = 0; n < 40 && PCI_BUSY === 1'b1; n++) begin
         @(posedge REF_CLK);
         #1;
         if (PCI_DONE === 1'b1) p_rd = PCI_RDATA;
         nd = nd + {31'h0, PCI_DONE};
      end
      if (n == 40) begin
         miscompares++;
         conclude();
      end
      chk(nd, {31'h0, hit});
   endtask

   // Main sequence.
   initial begin
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1;
      rdc(OFF_BASE, 32'h0, 0);
      rdc(OFF_BOUND, 32'h0, 0);
      rdc(OFF_OFFSET, 32'h0, 0);
      rdc(OFF_CONTROL, 32'h0080_0000, 0);
      rdc(12'h200, 32'h0, 1);
      apb(1, OFF_BASE, 32'h1000_FFFF);
      rdc(OFF_BASE, 32'h1000_0000, 0);
      apb(1, OFF_BOUND, 32'h2000_0000);
      apb(1, OFF_OFFSET, 32'h0F00_0000);
      apb(1, OFF_CONTROL, 32'h8082_5100);
      rdc(OFF_CONTROL, 32'h8082_5100, 0);
      for (int i = 0; i < 4; i++) begin
         pci_op(wa[i], 0, 0);
         chk(hit, i == 1 || i == 2);
         if (hit) chk(v_addr, wa[i] + 32'h0F00_0000);
         if (hit) chk(p_rd, {v_addr[15:0], v_addr[31:16]});
         if (hit) chk(v_fl, 5'h0E);
      end
      pci_op(32'h1000_0000, 1, 0);
      chk(hit, 0);
      apb(1, OFF_BOUND, 32'h0);
      apb(1, OFF_OFFSET, 32'hF100_0000);
      pci_op(32'hFFFF_1234, 0, 0);
      chk(v_addr, 32'hF0FF_1234);
      pci_op(32'h0FFF_0000, 0, 0);
      chk(hit, 0);
      for (int s = 0; s < 3; s++) for (int w = 0; w < 4; w++) for (int v = 0; v < 2; v++) begin
         apb(1, OFF_CONTROL, 32'h8000_0000 | (w << 22) | (s << 16) | (v << 8));
         pci_op(32'h1000_0000, 0, 0);
         eb = v == 1 && s != 0 && w != 3;
         em = s != 0 && w == 3;
         chk({v_sp, v_w, v_fl[1:0]}, {s[2:0], w[1:0], eb, em});
      end
      lat <= 5;
      apb(1, OFF_CONTROL, 32'hC082_0000);
      pci_op(32'h1000_0010, 0, 1);
      chk({early, v_fl[4]}, 2'b11);
      chk(v_wd, ~32'h1000_0010);
      chk(p_rd, 32'h0);
      pci_op(32'h1000_0010, 0, 0);
      chk(early, 0);
      apb(1, OFF_CONTROL, 32'hC082_0001);
      pci_op(32'h1000_0020, 1, 1);
      chk({hit, early}, 2'b10);
      apb(1, OFF_CONTROL, 32'h4082_0000);
      pci_op(32'h1000_0000, 0, 0);
      chk(hit, 0);
      apb(0, OFF_STATUS, 0);
      chk({29'h0, rd[2:0]}, 32'h4);
      conclude();
   end

   // Guard against a hang anywhere.
   initial begin
      #2000000;
      miscompares++;
      conclude();
   end
endmodule // pci_to_vme_image_decode_tb

bind pci_to_vme_image_decode image_decode_checker chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N),
   .PCI_REQ(PCI_REQ), .PCI_ADDR(PCI_ADDR), .PCI_IO(PCI_IO), .PCI_WRITE(PCI_WRITE),
   .PCI_DONE(PCI_DONE), .PCI_MISS(PCI_MISS), .PCI_BUSY(PCI_BUSY), .VME_REQ(VME_REQ),
   .VME_ADDR(VME_ADDR), .VME_SPACE(VME_SPACE), .VME_WIDTH(VME_WIDTH),
   .VME_BLT_ALLOW(VME_BLT_ALLOW), .VME_MBLT_ALLOW(VME_MBLT_ALLOW), .VME_ACK(VME_ACK));
